// *** core/dws_ctrl.v ***
// DDR2 command controller: write burst interrupt, burst spacing and self refresh.
`timescale 1ns/10ps
`default_nettype none
`include "dws_defines.vh"

module dws_ctrl (
    input wire clk,
    input wire reset_n,
    input wire ce,
    input wire cfg_bl8,
    input wire [2:0] cfg_wl,
    input wire [2:0] cfg_twr,
    input wire odt_req,
    input wire req_valid,
    output wire req_ready,
    input wire [2:0] req_cmd,
    input wire [1:0] req_bank,
    input wire [12:0] req_row,
    input wire [9:0] req_col,
    input wire req_ap,
    input wire req_intr,
    output wire self_refresh,
    output wire ddr_cke,
    output wire ddr_cs_n,
    output wire ddr_ras_n,
    output wire ddr_cas_n,
    output wire ddr_we_n,
    output wire [1:0] ddr_ba,
    output wire [12:0] ddr_addr,
    output wire ddr_odt
);
    localparam [2:0] ST_RUN = 3'h1;
    localparam [2:0] ST_AOFF = 3'h2;
    localparam [2:0] ST_SELF = 3'h4;
    localparam [31:0] K_RAS = `DWS_TRAS_CK - 1, K_RP = `DWS_TRP_CK - 1, K_WTR = `DWS_TWTR_CK;
    localparam [31:0] K_RFC = `DWS_TRFC_CK - 1, K_XSNR = `DWS_TXSNR_CK - 1;
    localparam [31:0] K_XSRD = `DWS_TXSRD_CK - 1, K_AOFD = `DWS_TAOFD_CK;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [4:0] wr_age_q;
    reg wr_ap_q;
    reg wr_bl8_q;
    reg [`DWS_NBANK-1:0] bank_open_q;
    reg [`DWS_TMR_W-1:0] gwait_q;
    reg [`DWS_TMR_W-1:0] xsrd_q;
    reg cke_q;
    reg cs_n_q;
    reg [2:0] pins_q;
    reg [1:0] ba_q;
    reg [12:0] addr_q;
    reg odt_q;

    reg ok;
    reg ready_c;
    reg [4:0] bl_half;
    reg [4:0] wr_end;
    reg [4:0] wr_pre;
    reg [4:0] rd_after_wr;
    reg burst_done;
    reg intr_ok;
    reg [`DWS_TMR_W-1:0] bank_val;
    reg [2:0] pins_d;
    reg [12:0] addr_d;

    wire [`DWS_NBANK-1:0] bank_done;
    wire [`DWS_NBANK-1:0] bank_load;
    wire issue;
    wire gwait_done;
    wire xsrd_done;
    wire all_idle;
    wire bank_is_open;
    wire bank_is_done;

    assign issue = req_valid && ready_c;
    assign req_ready = ready_c;
    assign gwait_done = (gwait_q == {`DWS_TMR_W{1'b0}});
    assign xsrd_done = (xsrd_q == {`DWS_TMR_W{1'b0}});
    assign all_idle = (bank_open_q == {`DWS_NBANK{1'b0}}) && (&bank_done);
    assign bank_is_open = bank_open_q[req_bank];
    assign bank_is_done = bank_done[req_bank];

    // Command spacing derived from the programmed burst length, write latency and write recovery.
    always @* begin
        bl_half = cfg_bl8 ? `DWS_HALF_BL8 : `DWS_HALF_BL4;
        wr_end = {2'h0, cfg_wl} + bl_half;
        wr_pre = wr_end + {2'h0, cfg_twr};
        rd_after_wr = wr_end + K_WTR[4:0];
        burst_done = (wr_age_q >= bl_half);
        intr_ok = req_intr && cfg_bl8 && wr_bl8_q
            && !wr_ap_q
            && (wr_age_q == `DWS_INTR_GAP);
    end

    // Legality of the offered request in the current state.
    always @* begin
        ok = 1'b0;
        case (req_cmd)
            `DWS_REQ_ACT: begin
                ok = !bank_is_open && bank_is_done;
            end
            `DWS_REQ_RD: begin
                // A read never cuts a write burst short.
                ok = bank_is_open && burst_done && (wr_age_q >= rd_after_wr)
                    && xsrd_done;
            end
            `DWS_REQ_WR: begin
                // The cutting write may go to any open bank, with or without auto precharge.
                ok = bank_is_open && (burst_done || intr_ok);
            end
            `DWS_REQ_PRE: begin
                if (req_ap) begin
                    ok = burst_done && (&bank_done);
                end else begin
                    ok = burst_done && bank_is_done;
                end
            end
            `DWS_REQ_REF: begin
                ok = all_idle;
            end
            `DWS_REQ_SRE: begin
                ok = all_idle;
            end
            default: begin
                ok = 1'b1;
            end
        endcase
        ready_c = 1'b0;
        case (state_q)
            ST_RUN: begin
                ready_c = ce && gwait_done && ok;
            end
            ST_SELF: begin
                // Only the exit request is taken; refresh waits until after exit.
                ready_c = ce && (req_cmd == `DWS_REQ_SRX);
            end
            default: begin
                ready_c = 1'b0;
            end
        endcase
    end

    // Pin code and address of the command that goes out next.
    always @* begin
        pins_d = `DWS_PIN_NOP;
        addr_d = 13'h0000;
        case (req_cmd)
            `DWS_REQ_ACT: begin
                pins_d = `DWS_PIN_ACT;
                addr_d = req_row;
            end
            `DWS_REQ_RD: begin
                pins_d = `DWS_PIN_RD;
                addr_d = {2'h0, req_ap, req_col};
            end
            `DWS_REQ_WR: begin
                pins_d = `DWS_PIN_WR;
                addr_d = {2'h0, req_ap, req_col};
            end
            `DWS_REQ_PRE: begin
                pins_d = `DWS_PIN_PRE;
                addr_d[`DWS_AP_BIT] = req_ap;
            end
            `DWS_REQ_REF: begin
                pins_d = `DWS_PIN_REF;
            end
            default: begin
                pins_d = `DWS_PIN_NOP;
            end
        endcase
    end

    // Earliest precharge or activate of a bank after the command issued now.
    always @* begin
        bank_val = {`DWS_TMR_W{1'b0}};
        case (req_cmd)
            `DWS_REQ_ACT: begin
                bank_val = K_RAS[`DWS_TMR_W-1:0];
            end
            `DWS_REQ_RD: begin
                bank_val = {3'h0, bl_half - 5'h01};
            end
            `DWS_REQ_WR: begin
                // Recovery counts from where the full burst would end.
                if (req_ap) begin
                    bank_val = {3'h0, wr_pre} + K_RP[`DWS_TMR_W-1:0];
                end else begin
                    bank_val = {3'h0, wr_pre - 5'h01};
                end
            end
            `DWS_REQ_PRE: begin
                bank_val = K_RP[`DWS_TMR_W-1:0];
            end
            default: begin
                bank_val = {`DWS_TMR_W{1'b0}};
            end
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < `DWS_NBANK; gi = gi + 1) begin : g_bank
            assign bank_load[gi] = issue && (state_q == ST_RUN)
                && ((req_bank == gi) || ((req_cmd == `DWS_REQ_PRE) && req_ap));
            dws_gap_timer u_tmr (
                .clk(clk),
                .reset_n(reset_n),
                .ce(ce),
                .load(bank_load[gi]),
                .value(bank_val),
                .done(bank_done[gi])
            );
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    bank_open_q[gi] <= 1'b0;
                end else if (ce && bank_load[gi]) begin
                    if (req_cmd == `DWS_REQ_ACT) begin
                        bank_open_q[gi] <= 1'b1;
                    end else if ((req_cmd == `DWS_REQ_PRE)
                        || ((req_cmd == `DWS_REQ_WR || req_cmd == `DWS_REQ_RD) && req_ap)) begin
                        bank_open_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (issue && (req_cmd == `DWS_REQ_SRE)) begin
                    state_d = ST_AOFF;
                end
            end
            ST_AOFF: begin
                if (gwait_done) begin
                    state_d = ST_SELF;
                end
            end
            ST_SELF: begin
                if (issue) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_RUN;
            wr_age_q <= `DWS_AGE_MAX;
            wr_ap_q <= 1'b0;
            wr_bl8_q <= 1'b0;
            gwait_q <= {`DWS_TMR_W{1'b0}};
            xsrd_q <= {`DWS_TMR_W{1'b0}};
            cke_q <= 1'b0;
            cs_n_q <= 1'b1;
            pins_q <= `DWS_PIN_NOP;
            ba_q <= 2'h0;
            addr_q <= 13'h0000;
            odt_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cs_n_q <= 1'b1;
            pins_q <= `DWS_PIN_NOP;
            if (wr_age_q != `DWS_AGE_MAX) begin
                wr_age_q <= wr_age_q + 5'h01;
            end
            if (!gwait_done) begin
                gwait_q <= gwait_q - 1'b1;
            end
            if (!xsrd_done) begin
                xsrd_q <= xsrd_q - 1'b1;
            end
            // Termination stays off around self refresh until the read exit delay ends.
            odt_q <= odt_req && (state_d == ST_RUN) && (state_q == ST_RUN) && xsrd_done;
            if (state_q == ST_RUN) begin
                cke_q <= 1'b1;
                if (issue && (req_cmd == `DWS_REQ_SRE)) begin
                    gwait_q <= K_AOFD[`DWS_TMR_W-1:0];
                end else if (issue && (req_cmd != `DWS_REQ_NOP) && (req_cmd != `DWS_REQ_SRX)) begin
                    cs_n_q <= 1'b0;
                    pins_q <= pins_d;
                    ba_q <= req_bank;
                    addr_q <= addr_d;
                    if (req_cmd == `DWS_REQ_WR) begin
                        wr_age_q <= 5'h01;
                        wr_ap_q <= req_ap;
                        wr_bl8_q <= cfg_bl8;
                    end
                    if (req_cmd == `DWS_REQ_REF) begin
                        gwait_q <= K_RFC[`DWS_TMR_W-1:0];
                    end
                end
            end else if (state_q == ST_AOFF) begin
                if (gwait_done) begin
                    // Entry: refresh code with clock enable dropping, all banks idle.
                    cke_q <= 1'b0;
                    cs_n_q <= 1'b0;
                    pins_q <= `DWS_PIN_REF;
                end
            end else if (state_q == ST_SELF) begin
                cke_q <= issue;
                if (issue) begin
                    gwait_q <= K_XSNR[`DWS_TMR_W-1:0];
                    xsrd_q <= K_XSRD[`DWS_TMR_W-1:0];
                end
            end
        end
    end

    assign self_refresh = (state_q == ST_SELF);
    assign ddr_cke = cke_q;
    assign ddr_cs_n = cs_n_q;
    assign ddr_ras_n = pins_q[2];
    assign ddr_cas_n = pins_q[1];
    assign ddr_we_n = pins_q[0];
    assign ddr_ba = ba_q;
    assign ddr_addr = addr_q;
    assign ddr_odt = odt_q;
endmodule
`default_nettype wire

// *** core/dws_defines.vh ***
// Constants shared by the DDR2 write-interrupt and self-refresh command controller.
`ifndef DWS_DEFINES_VH
`define DWS_DEFINES_VH

// Controller clock period in picoseconds (50 MHz).
`define DWS_CLK_PERIOD_PS 20000

// Analog times in nanoseconds; least times round up to whole clocks.
`define DWS_TRP_NS 15
`define DWS_TRAS_NS 40
`define DWS_TWTR_NS 10
`define DWS_TRFC_NS 105
`define DWS_TXSNR_NS (`DWS_TRFC_NS + 10)
`define DWS_CK_UP(ns) (((ns) * 1000 + `DWS_CLK_PERIOD_PS - 1) / `DWS_CLK_PERIOD_PS)
`define DWS_TRP_CK `DWS_CK_UP(`DWS_TRP_NS)
`define DWS_TRAS_CK `DWS_CK_UP(`DWS_TRAS_NS)
`define DWS_TWTR_CK `DWS_CK_UP(`DWS_TWTR_NS)
`define DWS_TRFC_CK `DWS_CK_UP(`DWS_TRFC_NS)
`define DWS_TXSNR_CK `DWS_CK_UP(`DWS_TXSNR_NS)

// Times given in clocks.
`define DWS_TXSRD_CK 200
`define DWS_TAOFD_CK 3
`define DWS_INTR_GAP 5'h02
`define DWS_HALF_BL4 5'h02
`define DWS_HALF_BL8 5'h04

// Request codes on req_cmd.
`define DWS_REQ_NOP 3'h0
`define DWS_REQ_ACT 3'h1
`define DWS_REQ_RD 3'h2
`define DWS_REQ_WR 3'h3
`define DWS_REQ_PRE 3'h4
`define DWS_REQ_REF 3'h5
`define DWS_REQ_SRE 3'h6
`define DWS_REQ_SRX 3'h7

// Pin codes as {ras_n, cas_n, we_n}.
`define DWS_PIN_NOP 3'h7
`define DWS_PIN_ACT 3'h3
`define DWS_PIN_RD 3'h5
`define DWS_PIN_WR 3'h4
`define DWS_PIN_PRE 3'h2
`define DWS_PIN_REF 3'h1

// Address bit that carries auto precharge and precharge-all.
`define DWS_AP_BIT 10
`define DWS_NBANK 4
`define DWS_TMR_W 8
`define DWS_AGE_MAX 5'h1F

`endif

// *** core/dws_gap_timer.v ***
// Per-bank down counter that only ever extends its remaining wait.
`timescale 1ns/10ps
`default_nettype none
`include "dws_defines.vh"

module dws_gap_timer (
    input wire clk,
    input wire reset_n,
    input wire ce,
    input wire load,
    input wire [`DWS_TMR_W-1:0] value,
    output wire done
);
    reg [`DWS_TMR_W-1:0] cnt_q;
    wire [`DWS_TMR_W-1:0] cnt_dec;

    assign cnt_dec = (cnt_q != {`DWS_TMR_W{1'b0}}) ? cnt_q - 1'b1 : cnt_q;
    assign done = (cnt_q == {`DWS_TMR_W{1'b0}});

    // A shorter new wait never cuts an older, longer one.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= {`DWS_TMR_W{1'b0}};
        end else if (ce) begin
            if (load && (value > cnt_dec)) begin
                cnt_q <= value;
            end else begin
                cnt_q <= cnt_dec;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/dws_ctrl_properties.sv ***
// Checker of command spacing and self refresh behaviour at the controller pins.
`timescale 1ns/10ps
`default_nettype none
module dws_ctrl_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cfg_bl8,
    input wire logic self_refresh,
    input wire logic ddr_cke,
    input wire logic ddr_cs_n,
    input wire logic ddr_ras_n,
    input wire logic ddr_cas_n,
    input wire logic ddr_we_n,
    input wire logic [1:0] ddr_ba,
    input wire logic [12:0] ddr_addr,
    input wire logic ddr_odt
);
    wire [3:0] cmd = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
    wire wr = cmd == 4'h4;
    wire rd = cmd == 4'h5;
    wire pre = cmd == 4'h2;
    wire rf = cmd == 4'h1;
    reg [3:0] open_q;
    reg [7:0] xs_q;
    // Open rows are tracked from the pins; xs_q counts cycles since self refresh ended.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open_q <= 4'h0;
            xs_q <= 8'hFF;
        end else begin
            if (cmd == 4'h3)
                open_q[ddr_ba] <= 1'b1;
            if (pre && ddr_addr[10])
                open_q <= 4'h0;
            else if (pre || ((wr || rd) && ddr_addr[10]))
                open_q[ddr_ba] <= 1'b0;
            if (self_refresh)
                xs_q <= 8'h00;
            else if (xs_q != 8'hFF)
                xs_q <= xs_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wr_gap_one_a: assert property (wr |=> !wr)
        else $error("write followed write after one cycle");
    bl8_plain_gap_a: assert property (cfg_bl8 && wr |-> ##3 !wr)
        else $error("burst of eight write spaced by three");
    ap_no_intr_a: assert property (cfg_bl8 && wr && ddr_addr[10] |-> ##2 !wr)
        else $error("write with auto precharge was interrupted");
    wr_no_rd_a: assert property (wr |=> !rd [*2])
        else $error("read cut a write burst");
    wr_no_pre_a: assert property (cfg_bl8 && wr |=> !pre [*3])
        else $error("precharge cut a write burst");
    sre_idle_a: assert property (rf |-> open_q == 4'h0)
        else $error("refresh with a row open");
    odt_off_a: assert property ($fell(ddr_cke) |-> !$past(ddr_odt) && !$past(ddr_odt, 2)
        && !$past(ddr_odt, 3))
        else $error("termination not off before clock enable fell");
    sr_quiet_a: assert property (!ddr_cke && !$past(ddr_cke) |-> ddr_cs_n)
        else $error("command while clock enable low");
    srx_read_a: assert property (rd || ddr_odt |-> xs_q >= 8'hC8)
        else $error("read or termination too soon after exit");
    srx_cmd_a: assert property (!ddr_cs_n && !self_refresh |-> xs_q >= 8'h06)
        else $error("command too soon after exit");
endmodule
bind dws_ctrl dws_ctrl_checker u_chk (.clk, .reset_n, .cfg_bl8, .self_refresh, .ddr_cke,
    .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_addr, .ddr_odt);
`default_nettype wire

// *** dv/dws_dram_model.sv ***
// Behavioural memory device that counts illegal command sequences on its pins.
`timescale 1ns/10ps
`default_nettype none
module dws_dram_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cfg_bl8,
    input wire logic ddr_cke,
    input wire logic ddr_cs_n,
    input wire logic ddr_ras_n,
    input wire logic ddr_cas_n,
    input wire logic ddr_we_n,
    input wire logic [1:0] ddr_ba,
    input wire logic [12:0] ddr_addr,
    input wire logic ddr_odt,
    output logic [7:0] err_count
);
    wire [3:0] cmd = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
    wire [7:0] half = cfg_bl8 ? 8'h04 : 8'h02;
    reg [3:0] open_q;
    reg [7:0] age_q;
    reg ap_q;
    reg cke_q;
    // Only a two-cycle cut of a burst of eight without auto precharge is exempt from being early.
    wire wr_early = age_q < half - 8'h01 && !(cfg_bl8 && age_q == 8'h01 && !ap_q);
    // Any open bank takes a write, an interrupting one with auto precharge too.
    wire bad = (!ddr_cke && !cke_q && !ddr_cs_n)
        || (cmd == 4'h4 && (!open_q[ddr_ba] || wr_early))
        || ((cmd == 4'h5 || cmd == 4'h2) && age_q < half - 8'h01)
        || (cmd == 4'h3 && open_q[ddr_ba])
        || (cmd == 4'h1 && (open_q != 4'h0 || (!ddr_cke && ddr_odt)));
    // Clock enable toggling needs no recovery here.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open_q <= 4'h0;
            age_q <= 8'hFF;
            ap_q <= 1'b0;
            cke_q <= 1'b0;
            err_count <= 8'h00;
        end else begin
            cke_q <= ddr_cke;
            if (bad)
                err_count <= err_count + 8'h01;
            if (age_q != 8'hFF)
                age_q <= age_q + 8'h01;
            if (cmd == 4'h4) begin
                age_q <= 8'h00;
                ap_q <= ddr_addr[10];
            end
            if (cmd == 4'h3)
                open_q[ddr_ba] <= 1'b1;
            if (cmd == 4'h2 && ddr_addr[10])
                open_q <= 4'h0;
            else if (cmd == 4'h2 || ((cmd == 4'h4 || cmd == 4'h5) && ddr_addr[10]))
                open_q[ddr_ba] <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** dv/dws_ctrl_tb_top.sv ***
// Testbench for the write interrupt and self refresh command controller.
`timescale 1ns/10ps
`default_nettype none
`include "dws_defines.vh"
module dws_ctrl_tb_top;
    logic clk, reset_n, ce, cfg_bl8, odt_req, req_valid, req_ap, req_intr;
    logic [2:0] cfg_wl, cfg_twr, req_cmd;
    logic [1:0] req_bank;
    logic [12:0] req_row;
    logic [9:0] req_col;
    wire req_ready, self_refresh, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_odt;
    wire [1:0] ddr_ba;
    wire [12:0] ddr_addr;
    wire [7:0] err_count;
    integer bad_count = 0, n_compared = 0, cyc = 0, t_wr = 0, t_wr0 = 0;
    integer t_rd = 0, t_pre = 0, t_act = 0, t_up = 0, t_ref = 0, t_dn = 0;
    logic cke_prev = 1'b0;
    dws_ctrl DUT (.clk, .reset_n, .ce, .cfg_bl8, .cfg_wl, .cfg_twr, .odt_req, .req_valid,
        .req_ready, .req_cmd, .req_bank, .req_row, .req_col, .req_ap, .req_intr,
        .self_refresh, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba,
        .ddr_addr, .ddr_odt);
    dws_dram_model u_mem (.clk, .reset_n, .cfg_bl8, .ddr_cke, .ddr_cs_n, .ddr_ras_n,
        .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_addr, .ddr_odt, .err_count);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Stamps the cycle at which each command shows on the pins; a refresh only when clock enable is high.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (!ddr_cs_n && {ddr_ras_n, ddr_cas_n, ddr_we_n} == 3'h4) begin
            t_wr0 = t_wr;
            t_wr = cyc;
        end
        if (!ddr_cs_n && {ddr_ras_n, ddr_cas_n, ddr_we_n} == 3'h5)
            t_rd = cyc;
        if (!ddr_cs_n && {ddr_ras_n, ddr_cas_n, ddr_we_n} == 3'h2)
            t_pre = cyc;
        if (!ddr_cs_n && {ddr_ras_n, ddr_cas_n, ddr_we_n} == 3'h3)
            t_act = cyc;
        if (!ddr_cs_n && {ddr_ras_n, ddr_cas_n, ddr_we_n} == 3'h1 && ddr_cke)
            t_ref = cyc;
        if (ddr_cke && !cke_prev)
            t_up = cyc;
        if (!ddr_cke && cke_prev)
            t_dn = cyc;
        cke_prev = ddr_cke;
        if (cyc > 5000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic fail(input string msg);
        bad_count++;
        $display("CHECK FAILED t=%0t %s", $time, msg);
    endtask
    task automatic chk_gap(input string msg, input integer got, input integer lo, input integer hi);
        n_compared++;
        if ($isunknown(got) || got < lo || got > hi)
            fail(msg);
    endtask
    task automatic chk_bit(input string msg, input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
            fail(msg);
    endtask
    task automatic req(input [2:0] c, input [1:0] b, input logic ap, input logic intr);
        integer n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_cmd = c;
        req_bank = b;
        req_ap = ap;
        req_intr = intr;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 400) begin
            n++;
            @(posedge clk);
        end
        if (n >= 400)
            fail("request never taken");
    endtask
    task automatic idle(input integer n);
        @(negedge clk);
        req_valid = 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic test_intr;
        req(`DWS_REQ_ACT, 2'h0, 1'b0, 1'b0);
        req(`DWS_REQ_ACT, 2'h1, 1'b0, 1'b0);
        req(`DWS_REQ_WR, 2'h0, 1'b0, 1'b0);
        req(`DWS_REQ_WR, 2'h1, 1'b1, 1'b1);
        req(`DWS_REQ_PRE, 2'h0, 1'b0, 1'b0);
        idle(3);
        chk_gap("interrupt spacing", t_wr - t_wr0, 2, 2);
        chk_gap("precharge after cut burst", t_pre - t_wr0, 9, 40);
        $display("test intr done");
    endtask
    task automatic test_plain;
        req(`DWS_REQ_ACT, 2'h0, 1'b0, 1'b0);
        req(`DWS_REQ_ACT, 2'h1, 1'b0, 1'b0);
        req(`DWS_REQ_WR, 2'h0, 1'b0, 1'b0);
        req(`DWS_REQ_WR, 2'h1, 1'b0, 1'b0);
        idle(3);
        chk_gap("gapless burst of eight", t_wr - t_wr0, 4, 4);
        req(`DWS_REQ_WR, 2'h0, 1'b1, 1'b0);
        req(`DWS_REQ_WR, 2'h1, 1'b0, 1'b1);
        req(`DWS_REQ_RD, 2'h1, 1'b0, 1'b0);
        idle(3);
        chk_gap("cut of auto precharge write", t_wr - t_wr0, 4, 40);
        chk_gap("read after write", t_rd - t_wr, 7, 40);
        @(negedge clk);
        cfg_bl8 = 1'b0;
        req(`DWS_REQ_WR, 2'h1, 1'b0, 1'b0);
        req(`DWS_REQ_WR, 2'h1, 1'b0, 1'b1);
        idle(12);
        chk_gap("gapless burst of four", t_wr - t_wr0, 2, 2);
        @(negedge clk);
        cfg_bl8 = 1'b1;
        $display("test plain done");
    endtask
    task automatic test_sr;
        integer n;
        n = 0;
        req(`DWS_REQ_PRE, 2'h0, 1'b1, 1'b0);
        req(`DWS_REQ_REF, 2'h0, 1'b0, 1'b0);
        req(`DWS_REQ_SRE, 2'h0, 1'b0, 1'b0);
        idle(1);
        while (self_refresh !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        idle(20);
        chk_bit("clock enable low", ddr_cke, 1'b0);
        chk_bit("termination off", ddr_odt, 1'b0);
        chk_gap("refresh to entry", t_dn - t_ref, `DWS_TRFC_CK + `DWS_TAOFD_CK + 1, 40);
        @(negedge clk);
        ce = 1'b0;
        req_cmd = `DWS_REQ_SRX;
        repeat (3) @(posedge clk);
        chk_bit("exit held while frozen", req_ready, 1'b0);
        chk_bit("frozen in self refresh", self_refresh, 1'b1);
        @(negedge clk);
        ce = 1'b1;
        req(`DWS_REQ_SRX, 2'h0, 1'b0, 1'b0);
        req(`DWS_REQ_ACT, 2'h0, 1'b0, 1'b0);
        req(`DWS_REQ_RD, 2'h0, 1'b0, 1'b0);
        idle(3);
        chk_gap("command after exit", t_act - t_up, `DWS_TXSNR_CK, 40);
        chk_gap("read after exit", t_rd - t_up, 200, 260);
        chk_bit("termination back", ddr_odt, 1'b1);
        $display("test self refresh done");
    endtask
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {reset_n, req_valid, req_ap, req_intr} = 4'h0;
        {ce, cfg_bl8, odt_req} = 3'h7;
        cfg_wl = 3'h2;
        cfg_twr = 3'h3;
        req_cmd = `DWS_REQ_NOP;
        req_bank = 2'h0;
        req_row = 13'h0123;
        req_col = 10'h040;
        repeat (10) @(posedge clk);
        chk_bit("reset clock enable", ddr_cke, 1'b0);
        chk_bit("reset select", ddr_cs_n, 1'b1);
        @(negedge clk);
        reset_n = 1'b1;
        test_intr();
        test_plain();
        test_sr();
        chk_gap("device saw illegal commands", err_count, 0, 0);
        conclude();
    end
endmodule
`default_nettype wire
